// File: common/eds_paging_regs.vh
// Constants for extended data paging and stack checking
// Summary of operation
// - Write window address uses write page bits
// - Read window address uses read page bits
// - Window reads add one stall cycle
// - Window writes complete in one cycle
// - Page registers never change on wrap
// - Read-modify-write uses read page register
// - Low addresses map directly, pages ignored
// - Page zero in window raises address trap
// - Each nonzero page selects own 32K region
// - Small-RAM parts route window to external port
// - Near data reachable by direct addressing
// - Stack grows upward, push post-increments
// - Call push zero-extends upper byte
// - Exception push puts status low byte upper
// - Stack limit bit 0 forced zero
// - Push past limit raises stack trap
// - Stack address below 0800h raises trap
`ifndef EDS_PAGING_REGS_VH
`define EDS_PAGING_REGS_VH
`define EA_WINDOW_BIT 15
`define PAGE_LOW_BITS 9
`define PAGE_PSV_BIT 9
`define STACK_FLOOR 16'h0800
`define NEAR_TOP 16'h1FFF
`define EXT_PORT_BASE 24'h008000
`define READ_EXTRA_CYCLES 1
`define REG_RPAGE 2'h0
`define REG_WPAGE 2'h1
`define REG_STACK_LIMIT 2'h2
`define REG_STATUS 2'h3
`define RPAGE_RESET 10'h001
`define WPAGE_RESET 9'h001
`endif

// File: verilog/eds_addr_map.v
// Effective-address to extended-address mapping
`include "eds_paging_regs.vh"
module eds_addr_map (
  // Access
  input wire [15:0] i_ea,
  input wire [8:0] i_page,
  input wire i_small_ram,
  // Result
  output wire [23:0] o_ext_addr,
  output wire o_page_zero,
  output wire o_ext_port
);
  wire in_window;
  assign in_window = i_ea[`EA_WINDOW_BIT];
  // Window concatenation or direct low mapping
  assign o_ext_addr = in_window ? {i_page, i_ea[14:0]}
                                : {8'h00, i_ea};
  assign o_page_zero = in_window && (i_page == 9'h000);
  assign o_ext_port = i_small_ram && in_window &&
                      (o_ext_addr >= `EXT_PORT_BASE);
endmodule // eds_addr_map

// File: verilog/stack_check.v
// Stack limit and underflow checking
`include "eds_paging_regs.vh"
module stack_check (
  // Access
  input wire i_sp_use,
  input wire i_push,
  input wire [15:0] i_ea,
  input wire [15:0] i_limit,
  // Result
  output wire o_stack_err
);
  wire over;
  wire under;
  // Equal to limit is still allowed; only beyond traps
  assign over = i_push && (i_ea > i_limit);
  assign under = i_ea < `STACK_FLOOR;
  assign o_stack_err = i_sp_use && (over || under);
endmodule // stack_check

// File: verilog/eds_paging_stack_check.v
// Extended data paging, stack pointer and trap logic
//
// The address map and the plain strobed port were decided locally.
`include "eds_paging_regs.vh"
module eds_paging_stack_check (
  // Clock and reset
  input wire i_clk_sys,
  input wire i_rst_n,
  // Register port
  input wire [1:0] i_reg_addr,
  input wire [15:0] i_reg_wdata,
  input wire i_reg_wr,
  input wire i_reg_rd,
  output reg [15:0] o_reg_rdata,
  // Core data access
  input wire i_acc_rd,
  input wire i_acc_wr,
  input wire i_acc_rmw,
  input wire [15:0] i_acc_ea,
  input wire [15:0] i_acc_wdata,
  // Stack operations
  input wire i_push,
  input wire i_pop,
  input wire i_push_call,
  input wire i_push_exc,
  input wire [22:0] i_pc,
  input wire [7:0] i_status_low_byte,
  input wire [15:0] i_sp_load,
  input wire i_sp_load_en,
  // Part option
  input wire i_small_ram,
  // Memory side
  output reg [23:0] o_mem_addr,
  output reg [15:0] o_mem_wdata,
  output reg o_mem_rd,
  output reg o_mem_wr,
  output reg o_mem_ext_port,
  // Core status
  output reg o_stall,
  output reg o_addr_err_trap,
  output reg o_stack_err_trap,
  output reg [15:0] o_stack_pointer_reg
);
  reg rst_s1_q;
  reg rst_q;
  reg [9:0] read_page_select_q;
  reg [8:0] write_page_select_q;
  reg [15:0] stack_limit_reg_q;
  reg [15:0] sp_q;
  reg [15:0] sp_d;
  reg push_hi_q;
  reg [15:0] hi_word_q;
  reg rd_wait_q;
  reg [15:0] ea;
  reg [8:0] page;
  reg use_read_page;
  reg is_write;
  reg is_read;
  reg [15:0] wdata;
  wire [23:0] map_addr;
  wire map_page_zero;
  wire map_ext_port;
  wire stack_err;
  wire addr_err;
  wire [15:0] pc_hi_word;

  // Reset release through two flops
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_s1_q <= 1'b0;
      rst_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_q <= rst_s1_q;
    end
  end

  // Upper pushed word of the program counter
  assign pc_hi_word = i_push_exc ? {i_status_low_byte, 1'b0, i_pc[22:16]}
                                 : {8'h00, 1'b0, i_pc[22:16]};

  // Select access address, page and data
  always @*
  begin
    ea = i_acc_ea;
    wdata = i_acc_wdata;
    is_write = i_acc_wr;
    is_read = i_acc_rd;
    use_read_page = i_acc_rd || i_acc_rmw;
    if (i_push || push_hi_q)
    begin
      ea = sp_q;
      is_write = 1'b1;
      is_read = 1'b0;
      use_read_page = 1'b0;
      if (push_hi_q)
        wdata = hi_word_q;
      else if (i_push_call || i_push_exc)
        wdata = i_pc[15:0];
      else
        wdata = i_acc_wdata;
    end
    else if (i_pop)
    begin
      ea = sp_q - 16'h0002;
      is_write = 1'b0;
      is_read = 1'b1;
      use_read_page = 1'b1;
    end
    page = use_read_page ? read_page_select_q[8:0] : write_page_select_q;
  end

  eds_addr_map u_map (
    .i_ea(ea),
    .i_page(page),
    .i_small_ram(i_small_ram),
    .o_ext_addr(map_addr),
    .o_page_zero(map_page_zero),
    .o_ext_port(map_ext_port)
  );

  stack_check u_stack (
    .i_sp_use(i_push || push_hi_q || i_pop),
    .i_push(i_push || push_hi_q),
    .i_ea(ea),
    .i_limit({stack_limit_reg_q[15:1], 1'b0}),
    .o_stack_err(stack_err)
  );

  // Page zero trap only for accesses that really touch memory
  assign addr_err = map_page_zero && (is_read || is_write || i_acc_rmw);

  // Next stack pointer
  always @*
  begin
    sp_d = sp_q;
    if (i_sp_load_en)
      sp_d = {i_sp_load[15:1], 1'b0};
    else if ((i_push || push_hi_q) && !stack_err)
      sp_d = sp_q + 16'h0002;
    else if (i_pop && !stack_err)
      sp_d = sp_q - 16'h0002;
  end

  // Registers, stack pointer and memory drive
  always @(posedge i_clk_sys or negedge rst_q)
  begin
    if (!rst_q)
    begin
      read_page_select_q <= `RPAGE_RESET;
      write_page_select_q <= `WPAGE_RESET;
      stack_limit_reg_q <= 16'h0000;
      sp_q <= `STACK_FLOOR;
      push_hi_q <= 1'b0;
      hi_word_q <= 16'h0000;
      rd_wait_q <= 1'b0;
      o_reg_rdata <= 16'h0000;
      o_mem_addr <= 24'h000000;
      o_mem_wdata <= 16'h0000;
      o_mem_rd <= 1'b0;
      o_mem_wr <= 1'b0;
      o_mem_ext_port <= 1'b0;
      o_stall <= 1'b0;
      o_addr_err_trap <= 1'b0;
      o_stack_err_trap <= 1'b0;
      o_stack_pointer_reg <= `STACK_FLOOR;
    end
    else
    begin
      // Page registers change only on software writes
      if (i_reg_wr && i_reg_addr == `REG_RPAGE)
        read_page_select_q <= i_reg_wdata[9:0];
      if (i_reg_wr && i_reg_addr == `REG_WPAGE)
        write_page_select_q <= i_reg_wdata[8:0];
      if (i_reg_wr && i_reg_addr == `REG_STACK_LIMIT)
        stack_limit_reg_q <= {i_reg_wdata[15:1], 1'b0};
      // Register read data, one cycle later
      if (i_reg_rd)
      begin
        case (i_reg_addr)
          `REG_RPAGE: o_reg_rdata <= {6'h00, read_page_select_q};
          `REG_WPAGE: o_reg_rdata <= {7'h00, write_page_select_q};
          `REG_STACK_LIMIT:
            o_reg_rdata <= {stack_limit_reg_q[15:1], 1'b0};
          default: o_reg_rdata <= sp_q;
        endcase
      end
      else
        o_reg_rdata <= 16'h0000;
      // Second word of a program counter push
      push_hi_q <= (i_push_call || i_push_exc) && i_push && !stack_err;
      if (i_push_call || i_push_exc)
        hi_word_q <= pc_hi_word;
      sp_q <= sp_d;
      o_stack_pointer_reg <= sp_d;
      // Trap requests; offending access suppressed
      o_addr_err_trap <= addr_err;
      o_stack_err_trap <= stack_err;
      o_mem_addr <= map_addr;
      o_mem_wdata <= wdata;
      o_mem_ext_port <= map_ext_port;
      o_mem_wr <= is_write && !addr_err && !stack_err;
      o_mem_rd <= (is_read || i_acc_rmw) && !addr_err && !stack_err;
      // One stall cycle on each window read
      rd_wait_q <= (is_read || i_acc_rmw) && ea[`EA_WINDOW_BIT] &&
                   !addr_err && !stack_err && !rd_wait_q;
      o_stall <= (is_read || i_acc_rmw) && ea[`EA_WINDOW_BIT] &&
                 !addr_err && !stack_err && !rd_wait_q;
    end
  end
endmodule // eds_paging_stack_check

// File: sim/eds_mem_model.sv
// Far-side memory model that keeps what the block writes to the low 64K
module eds_mem_model (
  // Memory side of the block
  input logic i_clk_sys,
  input logic i_mem_wr,
  input logic [23:0] i_mem_addr,
  input logic [15:0] i_mem_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [0:65535];
  // Store accepted writes to the low 64K; reads need no answer here
  always @(posedge i_clk_sys)
  begin
    if (i_mem_wr && i_mem_addr[23:16] == 8'h00)
      mem[i_mem_addr[15:0]] <= i_mem_wdata;
  end
endmodule // eds_mem_model

// File: sim/eds_paging_stack_check_properties.sv
// Port assertions for paging, trap and stack behaviour
module eds_paging_stack_check_properties (
  // Watched ports
  input logic i_clk_sys, i_rst_n, i_acc_rd, i_acc_wr,
  input logic i_push, i_pop, i_push_call, i_push_exc,
  input logic [15:0] i_acc_ea, o_mem_wdata, o_stack_pointer_reg,
  input logic [7:0] i_status_low_byte,
  input logic [23:0] o_mem_addr,
  input logic o_mem_rd, o_mem_wr, o_stall,
  input logic o_addr_err_trap, o_stack_err_trap
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // Two PC words, upper one at the next word address
  sequence s_pc_up(b);
    o_mem_wr ##1 o_mem_wr && o_mem_wdata[15:8] == b
      && o_mem_addr == $past(o_mem_addr) + 24'h2;
  endsequence
  property p_low_wr;
    i_acc_wr && !i_acc_ea[15] |=> o_mem_wr && !o_stall
      && o_mem_addr == {8'h00, $past(i_acc_ea)};
  endproperty
  a_low_wr: assert property (p_low_wr) else $error("low write");
  property p_win_rd;
    i_acc_rd && i_acc_ea[15] |=> o_addr_err_trap || o_stall && o_mem_rd;
  endproperty
  a_win_rd: assert property (p_win_rd) else $error("window read");
  property p_sup;
    o_addr_err_trap || o_stack_err_trap |-> !o_mem_rd && !o_mem_wr;
  endproperty
  a_sup: assert property (p_sup) else $error("access not held");
  property p_push;
    i_push && !i_push_call && !i_push_exc |=> o_stack_err_trap || o_mem_wr
      && o_mem_addr[15:0] == $past(o_stack_pointer_reg)
      && o_stack_pointer_reg == $past(o_stack_pointer_reg) + 16'h2;
  endproperty
  a_push: assert property (p_push) else $error("push order");
  property p_pop;
    i_pop |=> o_stack_err_trap || o_mem_rd
      && o_stack_pointer_reg == $past(o_stack_pointer_reg) - 16'h2
      && o_mem_addr[15:0] == o_stack_pointer_reg;
  endproperty
  a_pop: assert property (p_pop) else $error("pop order");
  property p_under;
    i_pop && o_stack_pointer_reg < 16'h0802 |=> o_stack_err_trap;
  endproperty
  a_under: assert property (p_under) else $error("no underflow");
  property p_call;
    i_push && i_push_call |=> o_stack_err_trap or s_pc_up(8'h00);
  endproperty
  a_call: assert property (p_call) else $error("call push");
  property p_exc;
    i_push && i_push_exc |=> o_stack_err_trap
      or s_pc_up($past(i_status_low_byte, 2));
  endproperty
  a_exc: assert property (p_exc) else $error("exception push");
endmodule // eds_paging_stack_check_properties
bind eds_paging_stack_check eds_paging_stack_check_properties chk (.*);

// File: sim/eds_paging_stack_check_test.sv
// Self-checking bench for paging, traps and stack logic
`include "eds_paging_regs.vh"
module eds_paging_stack_check_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk_sys = 0, i_rst_n = 0, i_reg_wr = 0, i_reg_rd = 0;
  logic i_acc_rd = 0, i_acc_wr = 0, i_acc_rmw = 0, i_small_ram = 0;
  logic i_push = 0, i_pop = 0, i_push_call = 0, i_push_exc = 0;
  logic i_sp_load_en = 0;
  logic [1:0] i_reg_addr = 0;
  logic [15:0] i_reg_wdata = 0, i_acc_ea = 0, i_acc_wdata = 0, i_sp_load = 0;
  logic [22:0] i_pc = 23'h7ABCDE;
  logic [7:0] i_status_low_byte = 8'hA5;
  logic [15:0] o_reg_rdata, o_mem_wdata, o_stack_pointer_reg;
  logic [23:0] o_mem_addr;
  logic o_mem_rd, o_mem_wr, o_mem_ext_port, o_stall;
  logic o_addr_err_trap, o_stack_err_trap;
  int bad_count = 0, compares = 0;
  typedef struct packed {
    logic [1:0] op; logic [8:0] rp, wp; logic sr;
    logic [15:0] ea; logic [23:0] ad; logic tr;
  } row_t;
  // Access kind, pages, small-RAM part, address, expected map, trap
  row_t rows [9] = '{
    '{0, 2, 2, 0, 16'h8800, 24'h010800, 0},
    '{1, 2, 2, 0, 16'h8800, 24'h010800, 0},
    '{0, 1, 1, 1, 16'hFFFE, 24'h00FFFE, 0},
    '{0, 1, 1, 1, 16'h8000, 24'h008000, 0},
    '{1, 9'h1FF, 9'h1FF, 0, 16'hFFFE, 24'hFFFFFE, 0},
    '{1, 0, 0, 1, 16'h1234, 24'h001234, 0}, '{0, 0, 0, 0, 16'h9000, 0, 1},
    '{2, 3, 4, 0, 16'h8010, 24'h018010, 0}, '{1, 3, 0, 0, 16'h8010, 0, 1}};
  row_t r;
  eds_paging_stack_check dut (.*);
  eds_mem_model m (.i_clk_sys(i_clk_sys), .i_mem_wr(o_mem_wr),
    .i_mem_addr(o_mem_addr), .i_mem_wdata(o_mem_wdata));
  // Clock at 100 ns period
  always #50 i_clk_sys = ~i_clk_sys;
  task ck(input string n, input logic [23:0] s, e);
    compares++;
    if (s !== e)
    begin
      bad_count++;
      $display("FAIL %s exp %h seen %h", n, e, s);
    end
  endtask
  task print_verdict;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Drop every strobe after the request edge, then let outputs settle
  task step;
    @(posedge i_clk_sys);
    {i_reg_wr, i_reg_rd, i_acc_rd, i_acc_wr, i_acc_rmw} <= 5'h00;
    {i_push, i_pop, i_push_call, i_push_exc, i_sp_load_en} <= 5'h00;
    #1;
  endtask
  task rw(input logic [1:0] a, input logic [15:0] d);
    @(posedge i_clk_sys);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    step;
  endtask
  task rr(input logic [1:0] a, input logic [15:0] e);
    @(posedge i_clk_sys);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    step;
    ck("rdata", o_reg_rdata, e);
  endtask
  task ld(input logic [15:0] v);
    @(posedge i_clk_sys);
    i_sp_load <= v;
    i_sp_load_en <= 1'b1;
    step;
  endtask
  task so(input logic [3:0] k);
    @(posedge i_clk_sys);
    {i_push_exc, i_push_call, i_pop, i_push} <= k;
    step;
  endtask
  // Watchdog for a hung run
  initial
  begin
    #100000;
    bad_count++;
    print_verdict;
  end
  // Main sequence
  initial
  begin
    repeat (3) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    #1;
    ck("sp_rst", o_stack_pointer_reg, `STACK_FLOOR);
    rr(`REG_RPAGE, `RPAGE_RESET);
    foreach (rows[i])
    begin
      r = rows[i];
      rw(`REG_RPAGE, {7'h00, r.rp});
      rw(`REG_WPAGE, {7'h00, r.wp});
      @(posedge i_clk_sys);
      i_small_ram <= r.sr;
      i_acc_ea <= r.ea;
      {i_acc_rmw, i_acc_wr, i_acc_rd} <= 3'h1 << r.op;
      step;
      if (!r.tr) ck("addr", o_mem_addr, r.ad);
      ck("trap", o_addr_err_trap, r.tr);
      // Read-modify-write reads through the read page like a read
      ck("rd", o_mem_rd, r.op != 2'h1 && !r.tr);
      ck("wr", o_mem_wr, r.op == 2'h1 && !r.tr);
      ck("stall", o_stall, r.op != 2'h1 && r.ea[15] && !r.tr);
      ck("ext", o_mem_ext_port, r.sr && r.ad >= 24'h008000);
    end
    // Pages hold what the last row wrote
    rr(`REG_RPAGE, 16'h0003);
    rr(`REG_WPAGE, 16'h0000);
    rw(`REG_STACK_LIMIT, 16'h1FFF);
    rr(`REG_STACK_LIMIT, 16'h1FFE);
    ld(16'h1FFC);
    so(4'h1);
    ck("push_addr", o_mem_addr, 24'h001FFC);
    so(4'h1);
    ck("eq_push", o_stack_err_trap, 1'b0);
    so(4'h1);
    ck("over", o_stack_err_trap, 1'b1);
    ck("sp_kept", o_stack_pointer_reg, 16'h2000);
    so(4'h2);
    ck("pop_sp", o_stack_pointer_reg, 16'h1FFE);
    ld(16'h1000);
    so(4'h5);
    step;
    so(4'h9);
    step;
    // Model stores the upper exception word one edge later
    step;
    ck("call_lo", m.mem[24'h001000], 16'hBCDE);
    ck("call_hi", m.mem[24'h001002], 16'h007A);
    ck("exc_hi", m.mem[24'h001006], 16'hA57A);
    ld(`STACK_FLOOR);
    so(4'h2);
    ck("under", o_stack_err_trap, 1'b1);
    so(4'h1);
    ck("sp_up", o_stack_pointer_reg, 16'h0802);
    // Reset in mid-run brings pointer, traps and registers back
    @(posedge i_clk_sys);
    i_rst_n <= 1'b0;
    @(posedge i_clk_sys);
    #1;
    ck("sp_rst2", o_stack_pointer_reg, `STACK_FLOOR);
    ck("trap_rst", o_stack_err_trap, 1'b0);
    @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    rr(`REG_WPAGE, `WPAGE_RESET);
    rr(`REG_STACK_LIMIT, 16'h0000);
    print_verdict;
  end
endmodule // eds_paging_stack_check_test
